// ---- rtl/ate_pkg.sv ----
package ate_pkg;
   // value width shared by all comparisons (signed engineering units)
   localparam int ATE_VW = 16;
   localparam int ATE_TW = 5;
   localparam int ATE_NCH = 4;
   // alarm type codes
   localparam logic [4:0] ATE_OFF = 5'h00;
   localparam logic [4:0] ATE_DEV_HL = 5'h01;
   localparam logic [4:0] ATE_DEV_H = 5'h02;
   localparam logic [4:0] ATE_DEV_L = 5'h03;
   localparam logic [4:0] ATE_DEV_RNG = 5'h04;
   localparam logic [4:0] ATE_DEV_HL_SB = 5'h05;
   localparam logic [4:0] ATE_DEV_H_SB = 5'h06;
   localparam logic [4:0] ATE_DEV_L_SB = 5'h07;
   localparam logic [4:0] ATE_ABS_H = 5'h08;
   localparam logic [4:0] ATE_ABS_L = 5'h09;
   localparam logic [4:0] ATE_ABS_H_SB = 5'h0a;
   localparam logic [4:0] ATE_ABS_L_SB = 5'h0b;
   localparam logic [4:0] ATE_LOOP_BURN = 5'h0c;
   localparam logic [4:0] ATE_RATE = 5'h0d;
   localparam logic [4:0] ATE_SP_H = 5'h0e;
   localparam logic [4:0] ATE_SP_L = 5'h0f;
   localparam logic [4:0] ATE_MV_H = 5'h10;
   localparam logic [4:0] ATE_MV_L = 5'h11;
   localparam logic [4:0] ATE_RSP_H = 5'h12;
   localparam logic [4:0] ATE_RSP_L = 5'h13;
   // reset value of every type setting
   localparam logic [4:0] ATE_TYPE_RST = ATE_DEV_H;
   // channel index that may hold the loop burnout type
   localparam int ATE_LB_CH = 0;
endpackage

// ---- rtl/ate_cfg_mem.sv ----
`timescale 1ns/1ps
// per-channel settings store: type, value, upper and lower deviations
module ate_cfg_mem
   import ate_pkg::*;
#(
   parameter int NCH = ATE_NCH,
   parameter int W = ATE_TW + 3 * ATE_VW
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(NCH)-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   // registered read port
   input wire logic [$clog2(NCH)-1:0] rd_idx,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem_ff [NCH];

   // reset puts each type at the default, values at zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NCH; i++) begin
            mem_ff[i] <= {ATE_TYPE_RST, {(W-ATE_TW){1'b0}}};
         end
      end else if (wr_en) begin
         mem_ff[wr_idx] <= wr_data;
      end
   end

   // read data always from a register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_ff[rd_idx];
      end
   end
endmodule

// ---- rtl/ate_alarm_eval.sv ----
`timescale 1ns/1ps
//Contract
// (RULE1) type 3: pv below sp minus x
// (RULE2) type 4: alarm inside sp deviation band
// (RULE3) type 5: type 1 with standby
// (RULE4) type 6: type 2 with standby
// (RULE5) type 7: type 3 with standby
// (RULE6) type 8: pv above x
// (RULE7) type 9: pv below x
// (RULE8) type 10: type 8 with standby
// (RULE9) type 11: type 9 with standby
// (RULE10) type 12 only on channel one
// (RULE11) type 13 uses external rate detector
// (RULE12) type 14: set point above x
// (RULE13) type 15: set point below x
// (RULE14) type 16: mv above x, hc negative on
// (RULE15) type 17: mv below x, hc negative on
// (RULE16) type 18: remote set point above x
// (RULE17) type 19: remote set point below x
// (RULE18) independent upper/lower deviations per channel
// (RULE19) type 1: pv outside deviation band
// (RULE20) type 2: pv above sp plus x
// (RULE21) hc: upper uses heat, lower cool
// (RULE22) type defaults to 2 after reset
// (RULE23) standby holds off until non-alarm seen
// (RULE24) all channels re-evaluated each sample
module ate_alarm_eval
   import ate_pkg::*;
#(
   parameter int NCH = ATE_NCH,
   parameter int VW = ATE_VW
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // measured and computed values, valid on sample_stb
   input wire logic sample_stb,
   input wire logic signed [VW-1:0] process_value,
   input wire logic signed [VW-1:0] set_point,
   input wire logic signed [VW-1:0] manipulated_variable,
   input wire logic signed [VW-1:0] cool_manipulated_variable,
   input wire logic signed [VW-1:0] remote_set_point,
   // mode and external detector results
   input wire logic heat_cool_mode,
   input wire logic loop_burnout_alarm,
   input wire logic rate_alarm,
   input wire logic standby_restart,
   // settings write port
   input wire logic cfg_wr,
   input wire logic [$clog2(NCH)-1:0] cfg_ch,
   input wire logic [ATE_TW-1:0] cfg_type,
   input wire logic signed [VW-1:0] cfg_value,
   input wire logic signed [VW-1:0] cfg_upper,
   input wire logic signed [VW-1:0] cfg_lower,
   // results
   output logic cfg_reject,
   output logic [NCH-1:0] alarm_out,
   output logic [NCH-1:0] standby_active,
   output logic scan_busy
);
   localparam int CW = $clog2(NCH);
   localparam int MW = ATE_TW + 3 * VW;

   initial begin
      if (NCH < 2 || VW < 4) begin
         $error("ate_alarm_eval: unsupported NCH or VW");
      end
   end

   typedef enum logic [2:0] {
      ATE_S_IDLE = 3'b001,
      ATE_S_READ = 3'b010,
      ATE_S_EVAL = 3'b100
   } ate_state_t;

   ate_state_t state_ff;
   logic [CW-1:0] ch_ff;
   logic [MW-1:0] rd_data;
   logic [MW-1:0] wr_data;
   logic wr_ok;
   logic cfg_reject_ff;
   logic [NCH-1:0] alarm_ff;
   logic [NCH-1:0] standby_ff;
   logic signed [VW-1:0] pv_ff, sp_ff, mv_ff, mvc_ff, rsp_ff;
   logic hc_ff, lb_ff, rate_ff, restart_ff;

   // a loop burnout type on any channel but the first is refused
   assign wr_ok = cfg_wr &&
      !(cfg_type == ATE_LOOP_BURN && cfg_ch != CW'(ATE_LB_CH)) && // RULE10
      cfg_type <= ATE_RSP_L;
   assign wr_data = {cfg_type, cfg_value, cfg_upper, cfg_lower}; // RULE18

   ate_cfg_mem #(.NCH(NCH), .W(MW)) u_mem (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(wr_ok),
      .wr_idx(cfg_ch),
      .wr_data(wr_data),
      .rd_idx(ch_ff),
      .rd_data(rd_data)
   ); // RULE22

   // one-cycle reject flag for a refused write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reject_ff <= 1'b0;
      end else begin
         cfg_reject_ff <= cfg_wr && !wr_ok; // RULE10
      end
   end

   // latch a sample so a scan sees one consistent snapshot
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pv_ff <= '0;
         sp_ff <= '0;
         mv_ff <= '0;
         mvc_ff <= '0;
         rsp_ff <= '0;
         hc_ff <= 1'b0;
         lb_ff <= 1'b0;
         rate_ff <= 1'b0;
         restart_ff <= 1'b0;
      end else if (sample_stb && state_ff == ATE_S_IDLE) begin
         pv_ff <= process_value; // RULE24
         sp_ff <= set_point;
         mv_ff <= manipulated_variable;
         mvc_ff <= cool_manipulated_variable;
         rsp_ff <= remote_set_point;
         hc_ff <= heat_cool_mode;
         lb_ff <= loop_burnout_alarm;
         rate_ff <= rate_alarm;
         restart_ff <= standby_restart;
      end
   end

   // scan: read a channel, evaluate, step to the next
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ATE_S_IDLE;
         ch_ff <= '0;
      end else begin
         case (state_ff)
            ATE_S_IDLE: begin
               if (sample_stb) begin
                  state_ff <= ATE_S_READ; // RULE24
               end
               ch_ff <= '0;
            end
            ATE_S_READ: begin
               state_ff <= ATE_S_EVAL;
            end
            ATE_S_EVAL: begin
               if (ch_ff == CW'(NCH - 1)) begin
                  state_ff <= ATE_S_IDLE;
               end else begin
                  ch_ff <= ch_ff + 1'b1;
                  state_ff <= ATE_S_READ;
               end
            end
            default: begin
               state_ff <= ATE_S_IDLE;
            end
         endcase
      end
   end

   // decoded fields of the channel being evaluated
   logic [ATE_TW-1:0] typ;
   logic signed [VW:0] x, hi, lo, pv, sp, mv, mvc, rsp, dev;
   assign typ = rd_data[MW-1 -: ATE_TW];
   assign x = {rd_data[3*VW-1], rd_data[3*VW-1 -: VW]};
   assign hi = {rd_data[2*VW-1], rd_data[2*VW-1 -: VW]};
   assign lo = {rd_data[VW-1], rd_data[VW-1:0]};
   assign pv = {pv_ff[VW-1], pv_ff};
   assign sp = {sp_ff[VW-1], sp_ff};
   assign mv = {mv_ff[VW-1], mv_ff};
   assign mvc = {mvc_ff[VW-1], mvc_ff};
   assign rsp = {rsp_ff[VW-1], rsp_ff};
   assign dev = pv - sp; // 17-bit so no wrap on extremes

   logic raw; // condition before standby
   logic sb_type; // type carries a standby sequence
   logic mv_neg_on;

   // comparison per type; deviation limits inclusive except the strict band of types 1 and 5, absolutes strict
   always_comb begin
      raw = 1'b0;
      sb_type = 1'b0;
      mv_neg_on = hc_ff && x < 0;
      case (typ)
         ATE_DEV_HL: raw = dev > hi || dev < -lo; // RULE19
         ATE_DEV_H: raw = dev >= x; // RULE20
         ATE_DEV_L: raw = dev <= -x; // RULE1
         ATE_DEV_RNG: raw = dev <= hi && dev >= -lo; // RULE2
         ATE_DEV_HL_SB: begin
            raw = dev > hi || dev < -lo; // RULE3
            sb_type = 1'b1;
         end
         ATE_DEV_H_SB: begin
            raw = dev >= x; // RULE4
            sb_type = 1'b1;
         end
         ATE_DEV_L_SB: begin
            raw = dev <= -x; // RULE5
            sb_type = 1'b1;
         end
         ATE_ABS_H: raw = pv > x; // RULE6
         ATE_ABS_L: raw = pv < x; // RULE7
         ATE_ABS_H_SB: begin
            raw = pv > x; // RULE8
            sb_type = 1'b1;
         end
         ATE_ABS_L_SB: begin
            raw = pv < x; // RULE9
            sb_type = 1'b1;
         end
         ATE_LOOP_BURN: raw = lb_ff && ch_ff == CW'(ATE_LB_CH); // RULE10
         ATE_RATE: raw = rate_ff; // RULE11
         ATE_SP_H: raw = sp > x; // RULE12
         ATE_SP_L: raw = sp < x; // RULE13
         ATE_MV_H: raw = mv_neg_on || mv > x; // RULE14 RULE21
         ATE_MV_L: raw = mv_neg_on || (hc_ff ? mvc : mv) < x; // RULE15 RULE21
         ATE_RSP_H: raw = rsp > x; // RULE16
         ATE_RSP_L: raw = rsp < x; // RULE17
         default: raw = 1'b0;
      endcase
   end

   // standby: armed until a clear condition has been seen
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic hit;
         assign hit = state_ff == ATE_S_EVAL && ch_ff == CW'(g);
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               standby_ff[g] <= 1'b1;
               alarm_ff[g] <= 1'b0;
            end else if (wr_ok && cfg_ch == CW'(g)) begin
               // new setting rearms standby and drops the alarm
               standby_ff[g] <= 1'b1;
               alarm_ff[g] <= 1'b0;
            end else if (hit) begin
               if (restart_ff && sb_type) begin
                  standby_ff[g] <= 1'b1; // RULE23
                  alarm_ff[g] <= 1'b0;
               end else if (sb_type && standby_ff[g]) begin
                  standby_ff[g] <= raw; // RULE23
                  alarm_ff[g] <= 1'b0;
               end else begin
                  standby_ff[g] <= standby_ff[g] && !raw;
                  alarm_ff[g] <= raw; // RULE24
               end
            end
         end
      end
   endgenerate

   // outputs straight from flops
   assign cfg_reject = cfg_reject_ff;
   assign alarm_out = alarm_ff;
   assign standby_active = standby_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_busy <= 1'b0;
      end else begin
         scan_busy <= state_ff != ATE_S_IDLE || sample_stb;
      end
   end
endmodule

// ---- tb/ate_alarm_eval_chk.sv ----
`timescale 1ns/1ps
// port-level checks on the alarm evaluator
module ate_chk
   import ate_pkg::*;
#(
   parameter int NCH = ATE_NCH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // requests
   input wire logic sample_stb,
   input wire logic cfg_wr,
   input wire logic [$clog2(NCH)-1:0] cfg_ch,
   input wire logic [ATE_TW-1:0] cfg_type,
   // results
   input wire logic cfg_reject,
   input wire logic [NCH-1:0] alarm_out,
   input wire logic [NCH-1:0] standby_active,
   input wire logic scan_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // a write that must be stored
   wire acc = cfg_wr && cfg_type <= ATE_RSP_L && !(cfg_type == ATE_LOOP_BURN && cfg_ch != 0);
   // one scan: nine busy cycles (four read/eval pairs plus the tail), then idle
   sequence s_start;
      sample_stb && !scan_busy;
   endsequence
   sequence s_scan;
      scan_busy [*8] ##1 scan_busy ##1 !scan_busy;
   endsequence
   a_scan_length: assert property (s_start |=> s_scan)
      else $error("scan length wrong");
   a_no_start: assert property (!sample_stb && !scan_busy |=> !scan_busy)
      else $error("scan started without strobe");
   a_idle_hold: assert property (!scan_busy && !sample_stb && !cfg_wr |=> $stable(alarm_out))
      else $error("alarm moved while idle");
   a_alarm_cause: assert property ($changed(alarm_out) |-> $past(scan_busy) || $past(cfg_wr))
      else $error("alarm moved without scan or write");
   a_lb_refused: assert property (cfg_wr && cfg_type == ATE_LOOP_BURN && cfg_ch != 0 |=> cfg_reject)
      else $error("loop burnout on other channel taken");
   a_good_taken: assert property (acc |=> !cfg_reject)
      else $error("legal write refused");
   a_reject_cause: assert property (cfg_reject |-> $past(cfg_wr))
      else $error("refusal without write");
   a_wr_rearm: assert property (acc && !scan_busy && !sample_stb |=>
      !alarm_out[$past(cfg_ch)] && standby_active[$past(cfg_ch)])
      else $error("write did not rearm channel");
endmodule
bind ate_alarm_eval ate_chk #(.NCH(NCH)) u_chk (.clk(clk), .rst_b(rst_b),
   .sample_stb(sample_stb), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch), .cfg_type(cfg_type),
   .cfg_reject(cfg_reject), .alarm_out(alarm_out), .standby_active(standby_active),
   .scan_busy(scan_busy));

// ---- tb/tb_ate_alarm_eval.sv ----
`timescale 1ns/1ps
module tb_ate_alarm_eval
   import ate_pkg::*;
;
   logic clk = '0, rst_b = '0, sample_stb = '0, hc = '0, lb = '0, ra = '0, cfg_wr = '0;
   logic sr = '0;
   logic signed [15:0] pv = '0, sp = '0, mv = '0, cm = '0, rs = '0, cv = '0, cu = '0, cl = '0;
   logic [1:0] ch = '0;
   logic [4:0] ty = '0;
   wire cfg_reject, scan_busy;
   wire [3:0] alarm_out, standby_active;
   int n_fail = 0, n_compared = 0, cyc = 0;
   // standby restart is a level latched with the strobe, like the values
   ate_alarm_eval dut (.clk(clk), .rst_b(rst_b), .sample_stb(sample_stb),
      .process_value(pv), .set_point(sp), .manipulated_variable(mv),
      .cool_manipulated_variable(cm), .remote_set_point(rs), .heat_cool_mode(hc),
      .loop_burnout_alarm(lb), .rate_alarm(ra), .standby_restart(sr), .cfg_wr(cfg_wr),
      .cfg_ch(ch), .cfg_type(ty), .cfg_value(cv), .cfg_upper(cu), .cfg_lower(cl),
      .cfg_reject(cfg_reject), .alarm_out(alarm_out), .standby_active(standby_active),
      .scan_busy(scan_busy));
   always #10 clk = ~clk;
   task report_and_stop;
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one settings write, refusal seen in the cycle after it is taken
   task cfg(input logic [1:0] c, input logic [4:0] t, input logic signed [15:0] v, u, l,
      input logic rej);
      @(posedge clk);
      cfg_wr <= 1'h1;
      ch <= c;
      ty <= t;
      cv <= v;
      cu <= u;
      cl <= l;
      @(posedge clk);
      cfg_wr <= 1'h0;
      @(negedge clk);
      chk(cfg_reject, rej);
   endtask
   // one sample; last channel lands at the eighth edge, busy drops at the ninth
   task scan(input logic signed [15:0] p, s, m, c, r, input logic h, b, a,
      input logic [3:0] e);
      @(posedge clk);
      sample_stb <= 1'h1;
      pv <= p;
      sp <= s;
      mv <= m;
      cm <= c;
      rs <= r;
      hc <= h;
      lb <= b;
      ra <= a;
      @(posedge clk);
      sample_stb <= 1'h0;
      repeat (9) @(posedge clk);
      @(negedge clk);
      chk(scan_busy, 4'h0);
      chk(alarm_out, e);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(negedge clk);
      chk(standby_active, 4'hf);
      scan(5, 5, 0, 0, 0, 0, 0, 0, 4'hf);
      scan(4, 5, 0, 0, 0, 0, 0, 0, 4'h0);
      // deviation family, separate upper and lower widths
      cfg(0, ATE_DEV_HL, 0, 10, 5, 0);
      cfg(1, ATE_DEV_L, 5, 0, 0, 0);
      cfg(2, ATE_DEV_RNG, 0, 10, 5, 0);
      cfg(3, ATE_DEV_H, 10, 0, 0, 0);
      scan(110, 100, 0, 0, 0, 0, 0, 0, 4'hc);
      scan(95, 100, 0, 0, 0, 0, 0, 0, 4'h6);
      scan(94, 100, 0, 0, 0, 0, 0, 0, 4'h3);
      scan(111, 100, 0, 0, 0, 0, 0, 0, 4'h9);
      // absolute and set point limits at their edges
      cfg(0, ATE_ABS_H, 50, 0, 0, 0);
      cfg(1, ATE_ABS_L, 50, 0, 0, 0);
      cfg(2, ATE_SP_H, 50, 0, 0, 0);
      cfg(3, ATE_SP_L, 50, 0, 0, 0);
      scan(50, 51, 0, 0, 0, 0, 0, 0, 4'h4);
      scan(49, 49, 0, 0, 0, 0, 0, 0, 4'ha);
      // output level and remote set point
      cfg(0, ATE_MV_H, 20, 0, 0, 0);
      cfg(1, ATE_MV_L, 20, 0, 0, 0);
      cfg(2, ATE_RSP_H, -3, 0, 0, 0);
      cfg(3, ATE_RSP_L, -3, 0, 0, 0);
      scan(0, 0, 21, 0, -3, 0, 0, 0, 4'h1);
      scan(0, 0, 19, 5, -4, 1, 0, 0, 4'ha);
      cfg(0, ATE_MV_H, -1, 0, 0, 0);
      cfg(1, ATE_MV_L, -1, 0, 0, 0);
      scan(0, 0, 50, 50, 0, 1, 0, 0, 4'h7);
      // outside detectors, off, refused writes
      cfg(0, ATE_LOOP_BURN, 0, 0, 0, 0);
      cfg(1, ATE_RATE, 0, 0, 0, 0);
      cfg(2, ATE_OFF, 0, 0, 0, 0);
      scan(0, 0, 0, 0, 0, 0, 1, 1, 4'h3);
      cfg(1, ATE_LOOP_BURN, 0, 0, 0, 1);
      cfg(2, 5'h14, 0, 0, 0, 1);
      scan(0, 0, 0, 0, 0, 0, 1, 0, 4'h1);
      // standby types hold off until a clear scan
      cfg(0, ATE_DEV_H_SB, 10, 0, 0, 0);
      cfg(1, ATE_DEV_L_SB, 5, 0, 0, 0);
      cfg(2, ATE_ABS_H_SB, 50, 0, 0, 0);
      cfg(3, ATE_ABS_L_SB, 50, 0, 0, 0);
      scan(200, 100, 0, 0, 0, 0, 0, 0, 4'h0);
      scan(40, 100, 0, 0, 0, 0, 0, 0, 4'ha);
      scan(200, 100, 0, 0, 0, 0, 0, 0, 4'h5);
      cfg(0, ATE_DEV_HL_SB, 0, 10, 5, 0);
      scan(120, 100, 0, 0, 0, 0, 0, 0, 4'h4);
      scan(100, 100, 0, 0, 0, 0, 0, 0, 4'h4);
      scan(120, 100, 0, 0, 0, 0, 0, 0, 4'h5);
      // restart rearms every standby channel and drops its alarm
      sr <= 1'h1;
      scan(120, 100, 0, 0, 0, 0, 0, 0, 4'h0);
      sr <= 1'h0;
      chk(standby_active, 4'hf);
      report_and_stop;
   end
endmodule
